// ==== rtl/asp_defs.svh ====
// register map, field positions and fixed counts of the serial port
`ifndef ASP_DEFS_SVH
`define ASP_DEFS_SVH
`define ASP_OFS_CTRL 8'h00
`define ASP_OFS_DATA 8'h04
`define ASP_OFS_BAUD 8'h08
`define ASP_CTRL_MODE 7
`define ASP_CTRL_MCE 5
`define ASP_CTRL_REN 4
`define ASP_CTRL_TB8 3
`define ASP_CTRL_RB8 2
`define ASP_CTRL_TI 1
`define ASP_CTRL_RI 0
`define ASP_BAUD_RUN 8
`define ASP_BAUD_SEL_LO 9
`define ASP_BAUD_SEL_HI 11
`define ASP_BAUD_IE 12
`define ASP_SEL_SYS 3'h0
`define ASP_SEL_DIV4 3'h1
`define ASP_SEL_DIV12 3'h2
`define ASP_SEL_DIV48 3'h3
`define ASP_SEL_OSC8 3'h4
`define ASP_SEL_EXT 3'h5
`define ASP_DIV4_LAST 2'h3
`define ASP_DIV12_LAST 4'hb
`define ASP_DIV48_LAST 6'h2f
`define ASP_DIV8_LAST 3'h7
`define ASP_TMR_TOP 8'hff
`define ASP_LAST_DATA_BIT 3'h7
`define ASP_PIN_IDLE 1'h1
`define ASP_SYNC_IDLE 2'h3
`define ASP_EXT_SYNC_RST 3'h0
`define ASP_RESP_OKAY 2'h0
`define ASP_RESP_SLVERR 2'h2
`endif

// ==== rtl/asp_pkg.sv ====
// types shared by the serial port modules
`default_nettype none
package asp_pkg;
	typedef enum logic [2:0] {
		TX_IDLE  = 3'h0,
		TX_START = 3'h1,
		TX_DATA  = 3'h3,
		TX_NINTH = 3'h2,
		TX_STOP  = 3'h6
	} asp_tx_e;
	typedef enum logic [2:0] {
		RX_IDLE  = 3'h0,
		RX_START = 3'h1,
		RX_DATA  = 3'h3,
		RX_NINTH = 3'h2,
		RX_STOP  = 3'h6
	} asp_rx_e;
	typedef struct packed {
		logic [7:0] reload;
		logic       run;
		logic [2:0] sel;
	} asp_baud_cfg_s;
	typedef struct packed {
		logic [7:0] cnt;
		logic       phase;
		logic       bit_tick;
	} asp_tmr_s;
	typedef struct packed {
		logic [1:0] c4;
		logic [3:0] c12;
		logic [5:0] c48;
		logic [2:0] c8;
		logic [2:0] osc_sync;
		logic [2:0] ext_sync;
		logic       tick;
	} asp_clk_s;
	typedef struct packed {
		logic       mode, mce, ren, tb8, rb8, ti, ri, ie;
		logic [7:0] reload;
		logic       run;
		logic [2:0] sel;
		logic [7:0] rx_buf, tx_buf;
		logic       tx_pend;
		asp_tx_e    tx_state;
		logic [8:0] tx_shift;
		logic [2:0] tx_cnt;
		logic       tx_pin;
		asp_rx_e    rx_state;
		logic [7:0] rx_shift;
		logic [2:0] rx_cnt;
		logic       rx_ninth;
		logic [1:0] rx_sync;
		logic       rx_force;
		logic       irq;
		logic       aw_hold, w_hold, awready, wready, bvalid, arready, rvalid;
		logic [7:0] aw_addr;
		logic [31:0] wdata, rdata;
		logic [3:0] wstrb;
		logic [1:0] bresp, rresp;
	} asp_top_s;
endpackage
`default_nettype wire

// ==== rtl/asp_clk_select.sv ====
// baud timer clock source selection and prescaling, one tick per timer clock
`timescale 1ns/10ps
`default_nettype none
`include "asp_defs.svh"
module asp_clk_select (
	input  wire logic               aclk,
	input  wire logic               aresetn,
	input  wire logic               ce,
	input  wire logic [2:0]         sel,
	input  wire logic               ext_osc_pin,
	input  wire logic               timer_ext_input,
	output logic                    tick
);
	import asp_pkg::*;
	asp_clk_s q, d;
	logic     osc_edge, ext_edge;

	// edges are taken after the second synchroniser stage only
	assign osc_edge = q.osc_sync[1] & ~q.osc_sync[2];
	assign ext_edge = q.ext_sync[1] & ~q.ext_sync[2];
	assign tick     = q.tick;

	// free running prescalers; the external oscillator is divided by 8 on its edges
	always_comb begin
		d          = q;
		d.osc_sync = {q.osc_sync[1:0], ext_osc_pin};
		d.ext_sync = {q.ext_sync[1:0], timer_ext_input};
		d.c4       = q.c4 + 2'h1;
		d.c12      = (q.c12 == `ASP_DIV12_LAST) ? 4'h0 : q.c12 + 4'h1;
		d.c48      = (q.c48 == `ASP_DIV48_LAST) ? 6'h00 : q.c48 + 6'h01;
		if (osc_edge) begin
			d.c8 = q.c8 + 3'h1;
		end
		unique case (sel)
			`ASP_SEL_SYS:   d.tick = 1'h1;
			`ASP_SEL_DIV4:  d.tick = (q.c4 == `ASP_DIV4_LAST);
			`ASP_SEL_DIV12: d.tick = (q.c12 == `ASP_DIV12_LAST);
			`ASP_SEL_DIV48: d.tick = (q.c48 == `ASP_DIV48_LAST);
			`ASP_SEL_OSC8:  d.tick = osc_edge && (q.c8 == `ASP_DIV8_LAST);
			`ASP_SEL_EXT:   d.tick = ext_edge;
			default:        d.tick = 1'h0; // unused codes stop the timer
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q          <= '0;
			q.ext_sync <= `ASP_EXT_SYNC_RST;
		end else if (ce) begin
			q <= d;
		end
	end
endmodule
`default_nettype wire

// ==== rtl/asp_baud_timer.sv ====
// 8-bit auto-reload baud timer with overflow halving and forced reload
`timescale 1ns/10ps
`default_nettype none
`include "asp_defs.svh"
module asp_baud_timer (
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire logic                  ce,
	input  wire asp_pkg::asp_baud_cfg_s cfg,
	input  wire logic                  tick,
	input  wire logic                  force_reload,
	output logic                       bit_tick
);
	import asp_pkg::*;
	asp_tmr_s q, d;

	assign bit_tick = q.bit_tick;

	// a forced reload primes the halver so the first overflow lands mid bit
	always_comb begin
		d          = q;
		d.bit_tick = 1'h0;
		if (force_reload) begin
			d.cnt   = cfg.reload;
			d.phase = 1'h1;
		end else if (cfg.run && tick) begin
			if (q.cnt == `ASP_TMR_TOP) begin
				d.cnt      = cfg.reload;
				d.bit_tick = q.phase;
				d.phase    = ~q.phase;
			end else begin
				d.cnt = q.cnt + 8'h01;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
		end else if (ce) begin
			q <= d;
		end
	end
endmodule
`default_nettype wire

// ==== rtl/asp_top.sv ====
// asynchronous serial port with AXI4-Lite register access
`timescale 1ns/10ps
`default_nettype none
`include "asp_defs.svh"
// Contract
// - data location writes load the transmit byte, never the received one
// - data location reads return the buffered receive byte only
// - completed receive byte is buffered while the next one arrives
// - transmit and receive done flags clear only by software write
// - interrupt requested while enabled and either done flag is set
// - transmit bit clock comes from the 8-bit auto-reload timer low byte
// - hidden receive timer runs with the baud timer, same reload value
// - overflows halved for bit rate; overflow period is 256 minus reload
// - timer clock from six sources: sys, /4, /12, /48, osc/8, ext
// - start detected on receive pin forces receive timer reload
// - control bit 7 selects 8-bit or 9-bit framing
// - 8-bit frame: start, eight data bits lsb first, stop
// - 8-bit mode stores accepted stop bit in receive ninth bit flag
// - data write starts transmit; done flag sets as stop bit begins
// - reception only while receive enable bit 4 is one
// - 8-bit accept needs flag clear and, with multiproc, stop bit one
// - on overrun the first byte stays, the later byte is dropped
// - 9-bit frame: start, eight data, ninth from control bit 3, stop
// - 9-bit mode stores ninth bit, ignores the stop bit
// - 9-bit accept needs flag clear and, with multiproc, ninth bit one
// - multiprocessor enable lives at control bit 5
module asp_top (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        ce,
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	input  wire logic        serial_rx_pin,
	output logic             serial_tx_pin,
	input  wire logic        ext_osc_pin,
	input  wire logic        timer_ext_input,
	output logic             serial_port_irq
);
	import asp_pkg::*;
	asp_top_s      q, d;
	asp_baud_cfg_s cfg;
	logic          tmr_tick, tx_bit_tick, rx_bit_tick;
	logic          wr_fire, rx_line, bit9, accept, ctrl_wr, data_wr;

	// registered outputs only
	assign awready         = q.awready;
	assign wready          = q.wready;
	assign bresp           = q.bresp;
	assign bvalid          = q.bvalid;
	assign arready         = q.arready;
	assign rdata           = q.rdata;
	assign rresp           = q.rresp;
	assign rvalid          = q.rvalid;
	assign serial_tx_pin   = q.tx_pin;
	assign serial_port_irq = q.irq;

	// both timers share one configuration and one prescaled clock
	assign cfg     = '{reload: q.reload, run: q.run, sel: q.sel};
	assign rx_line = q.rx_sync[1];
	assign wr_fire = q.aw_hold && q.w_hold && !q.bvalid;
	assign ctrl_wr = wr_fire && q.wstrb[0] && (q.aw_addr == `ASP_OFS_CTRL);
	assign data_wr = wr_fire && q.wstrb[0] && (q.aw_addr == `ASP_OFS_DATA);

	asp_clk_select u_clk (
		.aclk            (aclk),
		.aresetn         (aresetn),
		.ce              (ce),
		.sel             (q.sel),
		.ext_osc_pin     (ext_osc_pin),
		.timer_ext_input (timer_ext_input),
		.tick            (tmr_tick)
	);

	// transmit timer is never forced: it free-runs from the reload value
	asp_baud_timer u_tx_tmr (
		.aclk         (aclk),
		.aresetn      (aresetn),
		.ce           (ce),
		.cfg          (cfg),
		.tick         (tmr_tick),
		.force_reload (1'h0),
		.bit_tick     (tx_bit_tick)
	);

	// receive copy of the timer, realigned on each start condition
	asp_baud_timer u_rx_tmr (
		.aclk         (aclk),
		.aresetn      (aresetn),
		.ce           (ce),
		.cfg          (cfg),
		.tick         (tmr_tick),
		.force_reload (q.rx_force),
		.bit_tick     (rx_bit_tick)
	);

	// in 9-bit mode the ninth data bit qualifies, otherwise the stop bit
	assign bit9   = q.mode ? q.rx_ninth : rx_line;
	assign accept = !q.ri && (!q.mce || bit9);

	// next state: bus slave first, then hardware flag sets so a set beats a clear
	always_comb begin
		d          = q;
		d.rx_force = 1'h0;
		d.rx_sync  = {q.rx_sync[0], serial_rx_pin};

		// address and data are taken independently, in either order
		if (awvalid && q.awready) begin
			d.aw_hold = 1'h1;
			d.aw_addr = awaddr;
		end
		if (wvalid && q.wready) begin
			d.w_hold = 1'h1;
			d.wdata  = wdata;
			d.wstrb  = wstrb;
		end
		if (q.bvalid && bready) begin
			d.bvalid = 1'h0;
		end
		if (wr_fire) begin
			d.aw_hold = 1'h0;
			d.w_hold  = 1'h0;
			d.bvalid  = 1'h1;
			d.bresp   = `ASP_RESP_OKAY;
			unique case (q.aw_addr)
				`ASP_OFS_CTRL: begin
					if (q.wstrb[0]) begin
						d.mode = q.wdata[`ASP_CTRL_MODE];
						d.mce  = q.wdata[`ASP_CTRL_MCE];
						d.ren  = q.wdata[`ASP_CTRL_REN];
						d.tb8  = q.wdata[`ASP_CTRL_TB8];
						d.rb8  = q.wdata[`ASP_CTRL_RB8];
						d.ti   = q.wdata[`ASP_CTRL_TI];
						d.ri   = q.wdata[`ASP_CTRL_RI];
					end
				end
				`ASP_OFS_DATA: begin
					if (q.wstrb[0]) begin
						d.tx_buf  = q.wdata[7:0];
						d.tx_pend = 1'h1;
					end
				end
				`ASP_OFS_BAUD: begin
					if (q.wstrb[0]) begin
						d.reload = q.wdata[7:0];
					end
					if (q.wstrb[1]) begin
						d.run = q.wdata[`ASP_BAUD_RUN];
						d.sel = q.wdata[`ASP_BAUD_SEL_HI:`ASP_BAUD_SEL_LO];
						d.ie  = q.wdata[`ASP_BAUD_IE];
					end
				end
				default: d.bresp = `ASP_RESP_SLVERR;
			endcase
		end

		// reads have no side effects; the transmit byte cannot be read back
		if (q.rvalid && rready) begin
			d.rvalid = 1'h0;
		end
		if (arvalid && q.arready) begin
			d.rvalid = 1'h1;
			d.rresp  = `ASP_RESP_OKAY;
			unique case (araddr)
				`ASP_OFS_CTRL: d.rdata = {24'h000000, q.mode, 1'h0, q.mce, q.ren,
					q.tb8, q.rb8, q.ti, q.ri};
				`ASP_OFS_DATA: d.rdata = {24'h000000, q.rx_buf};
				`ASP_OFS_BAUD: d.rdata = {19'h00000, q.ie, q.sel, q.run, q.reload};
				default: begin
					d.rdata = 32'h00000000;
					d.rresp = `ASP_RESP_SLVERR;
				end
			endcase
		end

		// transmitter advances on the transmit bit clock only
		if (tx_bit_tick) begin
			unique case (q.tx_state)
				TX_IDLE: begin
					if (q.tx_pend) begin
						d.tx_pin   = 1'h0;
						d.tx_shift = {q.tb8, q.tx_buf};
						// a write in this very cycle queues the next byte instead of being lost
						d.tx_pend  = data_wr;
						d.tx_state = TX_START;
					end
				end
				TX_START: begin
					d.tx_pin   = q.tx_shift[0];
					d.tx_shift = {1'h0, q.tx_shift[8:1]};
					d.tx_cnt   = 3'h0;
					d.tx_state = TX_DATA;
				end
				TX_DATA: begin
					if (q.tx_cnt == `ASP_LAST_DATA_BIT) begin
						if (q.mode) begin
							d.tx_pin   = q.tx_shift[0];
							d.tx_state = TX_NINTH;
						end else begin
							d.tx_pin   = `ASP_PIN_IDLE;
							d.ti       = 1'h1;
							d.tx_state = TX_STOP;
						end
					end else begin
						d.tx_pin   = q.tx_shift[0];
						d.tx_shift = {1'h0, q.tx_shift[8:1]};
						d.tx_cnt   = q.tx_cnt + 3'h1;
					end
				end
				TX_NINTH: begin
					d.tx_pin   = `ASP_PIN_IDLE;
					d.ti       = 1'h1;
					d.tx_state = TX_STOP;
				end
				TX_STOP: d.tx_state = TX_IDLE;
			endcase
		end

		// a low line while idle and enabled is a start; realign the receive timer
		unique case (q.rx_state)
			RX_IDLE: begin
				if (q.ren && !rx_line) begin
					d.rx_force = 1'h1;
					d.rx_state = RX_START;
				end
			end
			RX_START: begin
				// a tick left from before the forced reload would sample the start bit early
				if (rx_bit_tick && !q.rx_force) begin
					d.rx_cnt   = 3'h0;
					// a start that is high at mid bit was a glitch
					d.rx_state = rx_line ? RX_IDLE : RX_DATA;
				end
			end
			RX_DATA: begin
				if (rx_bit_tick) begin
					d.rx_shift = {rx_line, q.rx_shift[7:1]};
					d.rx_cnt   = q.rx_cnt + 3'h1;
					if (q.rx_cnt == `ASP_LAST_DATA_BIT) begin
						d.rx_state = q.mode ? RX_NINTH : RX_STOP;
					end
				end
			end
			RX_NINTH: begin
				if (rx_bit_tick) begin
					d.rx_ninth = rx_line;
					d.rx_state = RX_STOP;
				end
			end
			RX_STOP: begin
				if (rx_bit_tick) begin
					// rejected frames leave buffer, ninth bit and flag untouched
					if (accept) begin
						d.rx_buf = q.rx_shift;
						d.rb8    = bit9;
						d.ri     = 1'h1;
					end
					d.rx_state = RX_IDLE;
				end
			end
		endcase

		// request follows the sticky flags, gated by the enable
		d.irq     = d.ie && (d.ti || d.ri);
		d.awready = !d.aw_hold && !d.bvalid;
		d.wready  = !d.w_hold && !d.bvalid;
		d.arready = !d.rvalid;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q         <= '0;
			q.tx_pin  <= `ASP_PIN_IDLE;
			q.rx_sync <= `ASP_SYNC_IDLE;
		end else if (ce) begin
			q <= d;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	data_write_tx_a: assert property (
		ce && wr_fire && q.wstrb[0] && q.aw_addr == `ASP_OFS_DATA
		|=> q.tx_pend && q.tx_buf == $past(q.wdata[7:0]))
		else $error("data write did not load the transmit byte");
	data_read_rx_a: assert property (
		ce && arvalid && q.arready && araddr == `ASP_OFS_DATA
		|=> q.rvalid && q.rdata[7:0] == $past(q.rx_buf))
		else $error("data read did not return the receive buffer");
	overrun_keep_a: assert property (
		ce && q.ri && !ctrl_wr |=> $stable(q.rx_buf) && q.ri)
		else $error("receive buffer changed while the done flag was set");
	flag_sticky_a: assert property (
		ce && q.ti && !ctrl_wr |=> q.ti)
		else $error("transmit done flag cleared without a write");
	irq_follow_a: assert property (
		ce |=> q.irq == (q.ie && (q.ti || q.ri)))
		else $error("interrupt request does not follow the flags");
	start_low_a: assert property (
		$rose(q.tx_state == TX_START) |-> !q.tx_pin ##1 !q.tx_pin)
		else $error("start bit is not low");
	stop_flag_a: assert property (
		$rose(q.tx_state == TX_STOP) |-> q.ti && q.tx_pin)
		else $error("stop bit began without the done flag");
	rx_enable_a: assert property (
		ce && q.rx_state == RX_IDLE && !q.ren |=> q.rx_state == RX_IDLE)
		else $error("reception started while disabled");
	rx_reject_keep_a: assert property (
		ce && q.rx_state == RX_STOP && rx_bit_tick && !accept && !ctrl_wr
		|=> $stable(q.rx_buf) && $stable(q.rb8) && $stable(q.ri))
		else $error("rejected frame changed the receive state");
	rx_stop_store_a: assert property (
		ce && q.rx_state == RX_STOP && rx_bit_tick && accept && !q.mode
		|=> q.ri && q.rb8 == $past(rx_line) && q.rx_buf == $past(q.rx_shift))
		else $error("accepted frame did not store stop bit and byte");
	rx_ninth_store_a: assert property (
		ce && q.rx_state == RX_STOP && rx_bit_tick && accept && q.mode
		|=> q.ri && q.rb8 == $past(q.rx_ninth))
		else $error("accepted frame did not store the ninth bit");
endmodule
`default_nettype wire

// ==== tb/asp_node.sv ====
// partner serial node: sends frames to the port and captures the port's frames
`timescale 1ns/10ps
`default_nettype none
module asp_node #(
	parameter int BIT = 32
) (
	input  wire logic aclk,
	input  wire logic line_in,
	input  wire logic nine,
	output var logic  line_out
);
	logic [7:0] data;
	logic       ninth;
	logic       stop;
	int         got = 0;
	int         per = BIT; // bit period in clocks; the bench changes it with the timer source

	// line idles high between frames
	initial line_out = 1'b1;

	// start low, data lsb first, ninth or stop, then stop and one idle bit
	task automatic send(input logic [7:0] d, input logic b9);
		logic [11:0] f;
		f = {2'b11, b9, d, 1'b0};
		@(posedge aclk);
		for (int i = 0; i < 12; i++) begin
			line_out <= f[i];
			repeat (per) @(posedge aclk);
		end
	endtask

	// capture mid-bit; waits for a high line first so an unknown at start is no edge
	always begin
		wait (line_in === 1'b1);
		@(negedge line_in);
		repeat (per / 2) @(posedge aclk);
		for (int i = 0; i < 8; i++) begin
			repeat (per) @(posedge aclk);
			data[i] = line_in;
		end
		if (nine) begin
			repeat (per) @(posedge aclk);
			ninth = line_in;
		end
		repeat (per) @(posedge aclk);
		stop = line_in;
		got++;
	end
endmodule
`default_nettype wire

// ==== tb/asp_top_test.sv ====
// self-checking bench for the serial port
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin failures++; \
	$display("BAD %s expected %h seen %h", nm, e, g); end end
module asp_top_test;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic        ce = 1'b1;
	logic [7:0]  awaddr = 8'h00;
	logic [7:0]  araddr = 8'h00;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic        arvalid = 1'b0, rready = 1'b0, nine = 1'b0, slow = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0]  wstrb = 4'h0;
	logic        awready, wready, bvalid, arready, rvalid, tx_line, rx_line, irq;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata, rd;
	int          failures = 0, samples_checked = 0;

	always #2 aclk = ~aclk;
	// slow pin clock: a rising edge every two cycles feeds the osc and external sources
	always @(posedge aclk) slow <= ~slow;

	asp_top dut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.serial_rx_pin(rx_line), .serial_tx_pin(tx_line), .ext_osc_pin(slow),
		.timer_ext_input(slow), .serial_port_irq(irq));
	// bit period 2*(256-0xf0) system clocks
	asp_node #(.BIT(32)) u_node (.aclk(aclk), .line_in(tx_line), .nine(nine), .line_out(rx_line));

	// write: address and data offered together, each released when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) begin
				bready <= 1'b0;
				`CHK("bresp", er, bresp)
				break;
			end
		end
	endtask

	task automatic rdr(input logic [7:0] a, input logic [1:0] er);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) begin
				rready <= 1'b0;
				rd = rdata;
				`CHK("rresp", er, rresp)
				break;
			end
		end
	endtask

	task automatic ctrl_is(input int pos, input logic e);
		rdr(8'h00, 2'h0);
		`CHK("control bit", e, rd[pos])
	endtask

	task automatic data_is(input logic [7:0] e);
		rdr(8'h04, 2'h0);
		`CHK("receive data", {24'h0, e}, rd)
	endtask

	task automatic send(input logic [7:0] d, input logic b9);
		u_node.send(d, b9);
		repeat (8) @(posedge aclk);
	endtask

	// write the data location and wait for the node to capture the frame
	task automatic tx_chk(input logic [7:0] d);
		int n;
		n = u_node.got;
		wr(8'h04, {24'h0, d}, 2'h0);
		for (int i = 0; i < 4000 && u_node.got == n; i++) @(posedge aclk);
		`CHK("frame seen", n + 1, u_node.got)
		`CHK("line data", d, u_node.data)
		`CHK("line stop", 1'b1, u_node.stop)
	endtask

	// each timer source at a reload whose bit period the node can follow
	task automatic src_chk(input logic [31:0] cw, input int p, input logic [7:0] d);
		wr(8'h08, cw, 2'h0);
		rdr(8'h08, 2'h0);
		`CHK("baud register", cw, rd)
		u_node.per = p;
		tx_chk(d);
	endtask

	task automatic final_report;
		$display("checks %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// watchdog sized well above the fifteen frames of the run
	initial begin
		repeat (80000) @(posedge aclk);
		failures++;
		final_report;
	end

	initial begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		rdr(8'h0c, 2'h2);
		`CHK("unmapped read", 32'h0, rd)
		wr(8'h0c, 32'h1, 2'h2);
		wr(8'h08, 32'h0000_11f0, 2'h0);
		wr(8'h00, 32'h10, 2'h0);
		tx_chk(8'ha5);
		ctrl_is(1, 1'b1);
		`CHK("irq on tx done", 1'b1, irq)
		wr(8'h00, 32'h10, 2'h0);
		repeat (2) @(posedge aclk);
		ctrl_is(1, 1'b0);
		`CHK("irq cleared", 1'b0, irq)
		send(8'h3c, 1'b1);
		ctrl_is(0, 1'b1);
		ctrl_is(2, 1'b1);
		`CHK("irq on rx done", 1'b1, irq)
		data_is(8'h3c);
		tx_chk(8'h77);
		data_is(8'h3c);
		send(8'hc3, 1'b1);
		data_is(8'h3c);
		wr(8'h00, 32'h30, 2'h0);
		send(8'h11, 1'b0);
		ctrl_is(0, 1'b0);
		send(8'h22, 1'b1);
		ctrl_is(0, 1'b1);
		data_is(8'h22);
		nine <= 1'b1;
		wr(8'h00, 32'hb0, 2'h0);
		send(8'h44, 1'b0);
		ctrl_is(0, 1'b0);
		send(8'h45, 1'b1);
		ctrl_is(0, 1'b1);
		ctrl_is(2, 1'b1);
		data_is(8'h45);
		wr(8'h00, 32'h88, 2'h0);
		send(8'h66, 1'b1);
		ctrl_is(0, 1'b0);
		tx_chk(8'h5a);
		`CHK("line ninth", 1'b1, u_node.ninth)
		src_chk(32'h0000_13fc, 32, 8'h96);
		src_chk(32'h0000_15fc, 96, 8'h69);
		src_chk(32'h0000_17ff, 96, 8'hc5);
		src_chk(32'h0000_19ff, 32, 8'h3a);
		src_chk(32'h0000_1bf8, 32, 8'h5c);
		final_report;
	end
endmodule
`default_nettype wire
